/* File: hw/fsl_log.sv */
// rolling log of the most recent operation records
// assumes one write at most per cycle from the limiter core
`timescale 1ns/1ps
module fsl_log
  import fsl_pkg::*;
#(
  parameter int DEPTH = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [31:0] w_time,
  input wire logic [2:0] w_code,
  input wire logic [7:0] w_used,
  input wire logic [31:0] w_since,
  input wire logic [31:0] w_inhdur,
  input wire logic [3:0] rd_age,
  input wire logic [1:0] rd_word,
  output logic [31:0] rd_data
);
  // state: record array, write pointer, fill count
  typedef struct packed {
    logic [DEPTH-1:0][106:0] rec;
    logic [3:0] wp;
    logic [3:0] fill;
  } fsl_log_state_type;
  fsl_log_state_type s_ff;
  fsl_log_state_type nxt_s;
  logic [3:0] idx;
  logic [106:0] sel;

  // next state: write the newest record and advance the ring
  always_comb
  begin
    nxt_s = s_ff;
    if (wr)
    begin
      nxt_s.rec[s_ff.wp] = {w_code, w_time, w_used, w_since, w_inhdur};
      nxt_s.wp = (s_ff.wp == 4'(DEPTH - 1)) ? 4'h0 : s_ff.wp + 4'h1;
      if (s_ff.fill != 4'(DEPTH))
      begin
        nxt_s.fill = s_ff.fill + 4'h1;
      end
    end
  end

  // read side: age 0 is the newest record; empty or old ages read zero
  always_comb
  begin
    idx = (s_ff.wp > rd_age) ? s_ff.wp - rd_age - 4'h1 : 4'(DEPTH) + s_ff.wp - rd_age - 4'h1;
    sel = (rd_age < s_ff.fill) ? s_ff.rec[idx] : '0;
    // record layout: code [106:104], time [103:72], used [71:64], since [63:32], inhibit [31:0]
    case (rd_word)
      2'h0: rd_data = sel[103:72];
      2'h1: rd_data = {21'h0, sel[106:104], sel[71:64]};
      2'h2: rd_data = sel[63:32];
      default: rd_data = sel[31:0];
    endcase
  end

  // register the whole state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // a write always moves the pointer within the ring
  a_log_ptr: assert property (@(posedge pclk) disable iff (!presetn)
    wr |=> (s_ff.wp == (($past(s_ff.wp) == 4'(DEPTH - 1)) ? 4'h0 : $past(s_ff.wp) + 4'h1)))
    else $error("log pointer did not advance");
endmodule

/* File: hw/fsl_map.svh */
// constant map of the frequent start limiter: offsets, fields, resets, timing
// assumes a 40 MHz pclk, APB byte addressing, settings kept in tenths
//
// Contract
// - motor hot when thermal use exceeds limit
// - cold safe stall time, default 20.0s
// - hot safe stall time, default 15.0s
// - no cold value given: use hot value
// - cold start allowance, default three
// - hot start allowance, default two
// - allowances apply over whole-hour window
// - minimum spacing between starts, default 20.0s
// - alarm while exactly one start remains
// - inhibit until a start is available again
// - blocked output when enabled but blocked
// - motor data settings shared with other functions
// - on/off events, user selects which stored
// - every event carries a time stamp
// - twelve most recent records kept, time-stamped
// - record holds used, since-start, inhibit time
// - outputs usable for direct control, logic
// - start adds stall time, counter decays
// - too-quick start blocks further starts
// - modes on, blocked, test, test-blocked, off
`ifndef FSL_MAP_SVH
`define FSL_MAP_SVH
// register byte offsets
`define FSL_OFS_CTRL 8'h00
`define FSL_OFS_HOTLIM 8'h04
`define FSL_OFS_STALL_C 8'h08
`define FSL_OFS_STALL_H 8'h0c
`define FSL_OFS_STARTS 8'h10
`define FSL_OFS_MINGAP 8'h14
`define FSL_OFS_STATUS 8'h18
`define FSL_OFS_SINCE 8'h1c
`define FSL_OFS_INHDUR 8'h20
`define FSL_OFS_LOGSEL 8'h24
`define FSL_OFS_LOGDAT 8'h28
// control field positions
`define FSL_CTRL_STON 3
`define FSL_CTRL_STOFF 4
`define FSL_CTRL_COLDGIV 5
// reset values (tenths of percent, tenths of seconds, counts, hours)
`define FSL_RST_HOTLIM 10'h2bc
`define FSL_RST_STALL_C 13'h00c8
`define FSL_RST_STALL_H 13'h0096
`define FSL_RST_N_COLD 7'h03
`define FSL_RST_N_HOT 7'h02
`define FSL_RST_HOURS 7'h01
`define FSL_RST_MINGAP 13'h00c8
// timing: program tick in ms, clock period in ns, ticks per hour
`define FSL_TICK_MS 100
`define FSL_CLK_NS 25
`define FSL_TICK_CYC (`FSL_TICK_MS * 1000000 / `FSL_CLK_NS)
`define FSL_TICKS_HOUR 36000
`define FSL_LOG_DEPTH 12
`define FSL_USED_MAX 8'h7f
`endif

/* File: hw/fsl_pkg.sv */
// types shared by the frequent start limiter and its record log
// assumes the constant map header is included by each user
package fsl_pkg;
  // operating mode field of the control register
  typedef enum logic [2:0]
  {
    FSL_MODE_ON = 3'h0,
    FSL_MODE_BLOCKED = 3'h1,
    FSL_MODE_TEST = 3'h2,
    FSL_MODE_TESTBLK = 3'h3,
    FSL_MODE_OFF = 3'h4
  } fsl_mode_type;
  // event codes, also the pending bit index
  typedef enum logic [2:0]
  {
    FSL_EV_ALARM_ON = 3'h0,
    FSL_EV_ALARM_OFF = 3'h1,
    FSL_EV_INH_ON = 3'h2,
    FSL_EV_INH_OFF = 3'h3,
    FSL_EV_BLK_ON = 3'h4,
    FSL_EV_BLK_OFF = 3'h5
  } fsl_event_type;
  // divider sequencer states, one-hot
  typedef enum logic [1:0]
  {
    FSL_ST_IDLE = 2'b01,
    FSL_ST_DIV = 2'b10
  } fsl_st_type;
endpackage

/* File: hw/fsl_top.sv */
// frequent start limiter core with APB register slave and record log
// assumes start pulses, thermal use, block input and time come from pclk logic
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "fsl_map.svh"
module fsl_top
  import fsl_pkg::*;
#(
  parameter int TICK_CYC = `FSL_TICK_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic motor_start_detect,
  input wire logic [9:0] thermal_used,
  input wire logic block_in,
  input wire logic [31:0] time_ms,
  output logic alarm,
  output logic inhibit,
  output logic blocked,
  output logic evt_valid,
  output logic [2:0] evt_code,
  output logic [31:0] evt_time,
  output logic [9:0] shared_hot_limit,
  output logic [12:0] shared_stall_cold,
  output logic [12:0] shared_stall_hot
);
  // whole state of the limiter
  typedef struct packed {
    fsl_st_type st;
    fsl_mode_type mode;
    logic st_on;
    logic st_off;
    logic cold_given;
    logic [9:0] hotlim;
    logic [12:0] stall_c;
    logic [12:0] stall_h;
    logic [6:0] n_c;
    logic [6:0] n_h;
    logic [6:0] hours;
    logic [12:0] mingap;
    logic [5:0] logsel;
    logic [39:0] cnt;
    logic [39:0] rem;
    logic [39:0] unit;
    logic [7:0] q;
    logic [7:0] used;
    logic [7:0] avail;
    logic [31:0] tick;
    logic [31:0] since;
    logic [31:0] inhdur;
    logic gapblk;
    logic hot;
    logic alarm;
    logic inhibit;
    logic blocked;
    logic [5:0] pend;
    logic evt_v;
    logic [2:0] evt_code;
    logic [31:0] evt_time;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fsl_state_type;
  fsl_state_type s_ff;
  fsl_state_type nxt_s;
  logic [31:0] log_data; // selected log word
  logic tick_now; // end of one program cycle
  logic active; // mode lets the function run
  logic blk; // function held off while enabled
  logic [12:0] stall; // stall time for the present thermal state
  logic [6:0] n_allow; // allowance for the present thermal state
  logic [39:0] hour_ticks; // window length in ticks
  logic [39:0] unit_now; // one start worth of counter
  logic [39:0] decay; // counter decay per tick
  logic wr_en; // APB write accepted this edge
  logic rd_en; // APB read answered this edge
  logic [5:0] chg; // output edges this cycle
  logic [2:0] pick; // lowest pending event
  logic pick_v; // any event pending

  // record log, written with every emitted event
  fsl_log #(
    .DEPTH(`FSL_LOG_DEPTH)
  ) u_log (
    .pclk(pclk),
    .presetn(presetn),
    .wr(s_ff.evt_v),
    .w_time(s_ff.evt_time),
    .w_code(s_ff.evt_code),
    .w_used(s_ff.used),
    .w_since(s_ff.since),
    .w_inhdur(s_ff.inhdur),
    .rd_age(s_ff.logsel[3:0]),
    .rd_word(s_ff.logsel[5:4]),
    .rd_data(log_data)
  );

  // derived terms used by the next-state logic
  always_comb
  begin
    tick_now = (s_ff.tick == 32'(TICK_CYC - 1));
    active = (s_ff.mode == FSL_MODE_ON) || (s_ff.mode == FSL_MODE_TEST);
    blk = (s_ff.mode == FSL_MODE_BLOCKED) || (s_ff.mode == FSL_MODE_TESTBLK)
      || (active && block_in);
    // cold stall falls back to the hot figure when none was given
    stall = s_ff.hot ? s_ff.stall_h : (s_ff.cold_given ? s_ff.stall_c : s_ff.stall_h);
    n_allow = s_ff.hot ? s_ff.n_h : s_ff.n_c;
    hour_ticks = 40'(s_ff.hours) * 40'(`FSL_TICKS_HOUR);
    // counter is scaled by the window so that decay stays integral
    unit_now = 40'(stall) * hour_ticks;
    decay = 40'(n_allow) * 40'(stall);
    wr_en = psel && penable && pwrite && s_ff.pready;
    rd_en = psel && penable && !pwrite && !s_ff.pready;
    chg[0] = !s_ff.alarm && alarm_nxt();
    chg[1] = s_ff.alarm && !alarm_nxt();
    chg[2] = !s_ff.inhibit && inh_nxt();
    chg[3] = s_ff.inhibit && !inh_nxt();
    chg[4] = !s_ff.blocked && blk;
    chg[5] = s_ff.blocked && !blk;
    pick = 3'h0;
    pick_v = 1'b0;
    for (int i = 5; i >= 0; i--)
    begin
      if (s_ff.pend[i])
      begin
        pick = 3'(i);
        pick_v = 1'b1;
      end
    end
  end

  // alarm when exactly one start is left, only while running unblocked
  function automatic logic alarm_nxt();
    alarm_nxt = active && !blk && (s_ff.avail == 8'h01);
  endfunction

  // inhibit when starts are spent or a start came too soon
  function automatic logic inh_nxt();
    inh_nxt = active && !blk && ((s_ff.avail == 8'h00) || s_ff.gapblk);
  endfunction

  // next state: registers, counter, divider, outputs and events
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = tick_now ? 32'h0 : s_ff.tick + 32'h1;
    nxt_s.hot = (thermal_used > s_ff.hotlim);
    // start counter: a start adds one stall, each tick removes a share
    if (active && motor_start_detect)
    begin
      nxt_s.cnt = s_ff.cnt + unit_now;
      nxt_s.since = 32'h0;
      if (s_ff.since < 32'(s_ff.mingap))
      begin
        nxt_s.gapblk = 1'b1;
      end
    end
    else if (tick_now)
    begin
      nxt_s.cnt = (s_ff.cnt > decay) ? s_ff.cnt - decay : 40'h0;
      nxt_s.since = (s_ff.since == 32'hffffffff) ? s_ff.since : s_ff.since + 32'h1;
      if (s_ff.since + 32'h1 >= 32'(s_ff.mingap))
      begin
        nxt_s.gapblk = 1'b0;
      end
    end
    // inhibit duration counts while inhibit stands
    if (!s_ff.inhibit)
    begin
      nxt_s.inhdur = 32'h0;
    end
    else if (tick_now)
    begin
      nxt_s.inhdur = s_ff.inhdur + 32'h1;
    end
    // divider: used starts are the counter over one stall, rounded up
    case (s_ff.st)
      FSL_ST_IDLE:
      begin
        if (tick_now)
        begin
          nxt_s.rem = s_ff.cnt;
          nxt_s.unit = (unit_now == 40'h0) ? 40'h1 : unit_now;
          nxt_s.q = 8'h0;
          nxt_s.st = FSL_ST_DIV;
        end
      end
      FSL_ST_DIV:
      begin
        if ((s_ff.rem == 40'h0) || (s_ff.q == `FSL_USED_MAX))
        begin
          nxt_s.used = s_ff.q;
          nxt_s.avail = (8'(n_allow) > s_ff.q) ? 8'(n_allow) - s_ff.q : 8'h0;
          nxt_s.st = FSL_ST_IDLE;
        end
        else
        begin
          nxt_s.rem = (s_ff.rem > s_ff.unit) ? s_ff.rem - s_ff.unit : 40'h0;
          nxt_s.q = s_ff.q + 8'h1;
        end
      end
      default:
      begin
        nxt_s.st = FSL_ST_IDLE;
      end
    endcase
    // function outputs for direct control and user logic
    nxt_s.alarm = alarm_nxt();
    nxt_s.inhibit = inh_nxt();
    nxt_s.blocked = blk && (s_ff.mode != FSL_MODE_OFF);
    // pending events: selection gates storage; a new edge beats the clear
    nxt_s.evt_v = pick_v;
    nxt_s.evt_code = pick;
    nxt_s.evt_time = time_ms;
    if (pick_v)
    begin
      nxt_s.pend[pick] = 1'b0;
    end
    for (int i = 0; i < 6; i++)
    begin
      if (chg[i] && ((i % 2 == 0) ? s_ff.st_on : s_ff.st_off))
      begin
        nxt_s.pend[i] = 1'b1;
      end
    end
    // APB: ready one cycle into access; write lands on the ready edge
    nxt_s.pready = psel && penable && !s_ff.pready;
    // error and read data stand only in the ready cycle
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata = 32'h0;
    if (psel && penable && !s_ff.pready)
    begin
      nxt_s.pslverr = (paddr > `FSL_OFS_LOGDAT) || (paddr[1:0] != 2'h0);
      case (paddr)
        `FSL_OFS_CTRL: nxt_s.prdata = {26'h0, s_ff.cold_given, s_ff.st_off, s_ff.st_on,
          s_ff.mode};
        `FSL_OFS_HOTLIM: nxt_s.prdata = {22'h0, s_ff.hotlim};
        `FSL_OFS_STALL_C: nxt_s.prdata = {19'h0, s_ff.stall_c};
        `FSL_OFS_STALL_H: nxt_s.prdata = {19'h0, s_ff.stall_h};
        `FSL_OFS_STARTS: nxt_s.prdata = {9'h0, s_ff.hours, 1'b0, s_ff.n_h, 1'b0, s_ff.n_c};
        `FSL_OFS_MINGAP: nxt_s.prdata = {19'h0, s_ff.mingap};
        `FSL_OFS_STATUS: nxt_s.prdata = {8'h0, s_ff.used, s_ff.avail, 3'h0, s_ff.gapblk,
          s_ff.hot, s_ff.blocked, s_ff.inhibit, s_ff.alarm};
        `FSL_OFS_SINCE: nxt_s.prdata = s_ff.since;
        `FSL_OFS_INHDUR: nxt_s.prdata = s_ff.inhdur;
        `FSL_OFS_LOGSEL: nxt_s.prdata = {26'h0, s_ff.logsel};
        `FSL_OFS_LOGDAT: nxt_s.prdata = log_data;
        default: nxt_s.prdata = 32'h0;
      endcase
      if (!rd_en)
      begin
        nxt_s.prdata = 32'h0;
      end
    end
    // settings writes; hot limit and stall times are the shared motor data
    if (wr_en && !s_ff.pslverr)
    begin
      case (paddr)
        `FSL_OFS_CTRL:
        begin
          // an unknown mode code is refused and the old mode stays
          if (pwdata[2:0] <= FSL_MODE_OFF)
          begin
            nxt_s.mode = fsl_mode_type'(pwdata[2:0]);
          end
          nxt_s.st_on = pwdata[`FSL_CTRL_STON];
          nxt_s.st_off = pwdata[`FSL_CTRL_STOFF];
          nxt_s.cold_given = pwdata[`FSL_CTRL_COLDGIV];
        end
        `FSL_OFS_HOTLIM: nxt_s.hotlim = pwdata[9:0];
        `FSL_OFS_STALL_C: nxt_s.stall_c = pwdata[12:0];
        `FSL_OFS_STALL_H: nxt_s.stall_h = pwdata[12:0];
        `FSL_OFS_STARTS:
        begin
          nxt_s.n_c = pwdata[6:0];
          nxt_s.n_h = pwdata[14:8];
          nxt_s.hours = pwdata[22:16];
        end
        `FSL_OFS_MINGAP: nxt_s.mingap = pwdata[12:0];
        `FSL_OFS_LOGSEL: nxt_s.logsel = pwdata[5:0];
        default: nxt_s.logsel = s_ff.logsel;
      endcase
    end
  end

  // register the state; reset loads the default settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= '0;
      s_ff.st <= FSL_ST_IDLE;
      s_ff.mode <= FSL_MODE_ON;
      s_ff.st_on <= 1'b1;
      s_ff.st_off <= 1'b1;
      s_ff.cold_given <= 1'b1;
      s_ff.hotlim <= `FSL_RST_HOTLIM;
      s_ff.stall_c <= `FSL_RST_STALL_C;
      s_ff.stall_h <= `FSL_RST_STALL_H;
      s_ff.n_c <= `FSL_RST_N_COLD;
      s_ff.n_h <= `FSL_RST_N_HOT;
      s_ff.hours <= `FSL_RST_HOURS;
      s_ff.mingap <= `FSL_RST_MINGAP;
      s_ff.avail <= 8'(`FSL_RST_N_COLD);
      s_ff.since <= 32'hffffffff;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // every output comes straight from the state register
  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign alarm = s_ff.alarm;
  assign inhibit = s_ff.inhibit;
  assign blocked = s_ff.blocked;
  assign evt_valid = s_ff.evt_v;
  assign evt_code = s_ff.evt_code;
  assign evt_time = s_ff.evt_time;
  assign shared_hot_limit = s_ff.hotlim;
  assign shared_stall_cold = s_ff.stall_c;
  assign shared_stall_hot = s_ff.stall_h;

  a_alarm_one: assert property (@(posedge pclk) disable iff (!presetn)
    (active && !blk && s_ff.avail == 8'h01) |=> alarm)
    else $error("alarm missing with one start left");
  a_inhibit_spent: assert property (@(posedge pclk) disable iff (!presetn)
    (active && !blk && s_ff.avail == 8'h00) |=> inhibit && !alarm)
    else $error("inhibit missing with no start left");
  a_blocked_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.mode == FSL_MODE_BLOCKED) |=> blocked && !inhibit)
    else $error("blocked mode not shown");
  a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.mode == FSL_MODE_OFF) |=> !alarm && !inhibit && !blocked)
    else $error("outputs active in off mode");
  a_hot_state: assert property (@(posedge pclk) disable iff (!presetn)
    (thermal_used > s_ff.hotlim) |=> s_ff.hot)
    else $error("hot state not taken");
  a_start_adds: assert property (@(posedge pclk) disable iff (!presetn)
    (active && motor_start_detect) |=> s_ff.cnt == $past(s_ff.cnt) + $past(unit_now))
    else $error("start did not add one stall");
  a_gap_block: assert property (@(posedge pclk) disable iff (!presetn)
    (active && motor_start_detect && s_ff.since < 32'(s_ff.mingap) && !blk)
    |=> s_ff.gapblk ##1 inhibit)
    else $error("quick start not blocked");
  a_event_out: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(alarm) && s_ff.st_on) |-> ##[0:6] (evt_valid && evt_code == FSL_EV_ALARM_ON))
    else $error("alarm on event not emitted");
  a_event_stamp: assert property (@(posedge pclk) disable iff (!presetn)
    evt_valid |-> evt_time == $past(time_ms))
    else $error("event stamp not taken");
endmodule

/* File: tb/fsl_motor_model.sv */
// far side model: start detection pulses, thermal use level, millisecond time
// assumes pclk domain and one-cycle start requests from the bench
`timescale 1ns/1ps
module fsl_motor_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start_req,
  input wire logic [9:0] heat_req,
  output logic motor_start_detect,
  output logic [9:0] thermal_used,
  output logic [31:0] time_ms
);
  logic [15:0] ms_div; // cycles within one millisecond at 40 MHz
  // one pulse per request; heat jumps to target, a ramp would waste cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      motor_start_detect <= 1'b0;
      thermal_used <= 10'h000;
      time_ms <= 32'h0;
      ms_div <= 16'h0;
    end
    else
    begin
      motor_start_detect <= start_req;
      thermal_used <= heat_req;
      ms_div <= (ms_div == 16'h9c3f) ? 16'h0 : ms_div + 16'h1;
      if (ms_div == 16'h9c3f)
        time_ms <= time_ms + 32'h1; // wall time advances once per ms
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the frequent start limiter through its apb port
// assumes the motor model drives start pulses, thermal use and time
`timescale 1ns/1ps
`include "fsl_map.svh"
module tb_top
  import fsl_pkg::*;
;
  localparam int TK = 50; // short program tick keeps the run brief
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, prev_time, time_ms, evt_time;
  logic start_req, block_in, motor_start_detect, alarm, inhibit, blocked, evt_valid;
  logic [2:0] evt_code, last_code;
  logic [9:0] heat_req, thermal_used, shared_hot_limit, lim;
  logic [12:0] shared_stall_cold, shared_stall_hot;
  logic [31:0] rst_tab [6]; // expected reset words of the first six registers
  int fails, checked, cyc, ev_cnt, n;
  fsl_top #(.TICK_CYC(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_start_detect(motor_start_detect), .thermal_used(thermal_used),
    .block_in(block_in), .time_ms(time_ms), .alarm(alarm), .inhibit(inhibit),
    .blocked(blocked), .evt_valid(evt_valid), .evt_code(evt_code),
    .evt_time(evt_time), .shared_hot_limit(shared_hot_limit),
    .shared_stall_cold(shared_stall_cold), .shared_stall_hot(shared_stall_hot));
  fsl_motor_model u_motor (.pclk(pclk), .presetn(presetn), .start_req(start_req),
    .heat_req(heat_req), .motor_start_detect(motor_start_detect),
    .thermal_used(thermal_used), .time_ms(time_ms));
  // starts word: cold, hot and hour fields
  function automatic logic [31:0] starts_word(input int c, input int h, input int hr);
    return {8'h0, 8'(hr), 8'(h), 8'(c)};
  endfunction
  // used and available fields as the status word packs them
  function automatic logic [15:0] counts(input int n, input int used);
    return {8'(used), 8'(n - used)};
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      fails++; // slave never answered
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one start pulse through the model, then idle cycles
  task automatic kick(input int gap);
    @(posedge pclk);
    start_req <= 1'b1;
    @(posedge pclk);
    start_req <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // hang guard; the long gap wait dominates the run
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  // event monitor: last code, count, stamp of the cycle before
  always @(posedge pclk)
  begin
    prev_time <= time_ms;
    if (evt_valid === 1'b1)
    begin
      last_code <= evt_code;
      ev_cnt <= ev_cnt + 1;
      chk(evt_time, prev_time, "event time");
    end
  end
  initial
  begin
    void'($urandom(61022));
    {psel, penable, pwrite, start_req, block_in} = 5'h0;
    {paddr, pwdata, heat_req, fails, checked, cyc, ev_cnt} = '0;
    presetn = 1'b0;
    rst_tab = '{32'h38, 32'h2bc, 32'hc8, 32'h96, starts_word(3, 2, 1), 32'hc8};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, rst_tab[i], "reset value");
    end
    chk(shared_stall_hot, 32'h96, "shared hot stall");
    chk(shared_stall_cold, 32'hc8, "shared cold stall");
    // unmapped place refuses and reads zero
    apb(1'b1, 8'h2c, $urandom());
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h2c, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    // random hot limit reaches the shared copy at once
    lim = 10'($urandom_range(999));
    apb(1'b1, `FSL_OFS_HOTLIM, {22'h0, lim});
    apb(1'b0, `FSL_OFS_HOTLIM, 32'h0);
    chk(rd, {22'h0, lim}, "hot limit");
    chk(shared_hot_limit, lim, "shared limit");
    // too-quick second start, cold motor with three allowed
    kick(2);
    kick(3);
    chk(inhibit, 1'b1, "gap inhibit");
    repeat (250) @(posedge pclk);
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[23:8], counts(3, 2), "counts two");
    chk(alarm, 1'b1, "alarm one left");
    chk(last_code, FSL_EV_ALARM_ON, "alarm event");
    n = 0;
    while (inhibit !== 1'b0 && n < 12000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(inhibit, 1'b0, "gap release");
    // last start used up
    kick(250);
    chk({alarm, inhibit}, 2'b01, "all used");
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[23:8], counts(3, 3), "counts three");
    chk(last_code, FSL_EV_INH_ON, "inhibit event");
    apb(1'b1, `FSL_OFS_LOGSEL, 32'h10);
    apb(1'b0, `FSL_OFS_LOGDAT, 32'h0);
    chk(rd[10:0], {3'h2, 8'h3}, "log record");
    // every mode in turn
    for (int m = 0; m < 5; m++)
    begin
      apb(1'b1, `FSL_OFS_CTRL, 32'h38 | m);
      repeat (3) @(posedge pclk);
      chk(blocked, m == 1 || m == 3, "mode blocked");
    end
    apb(1'b1, `FSL_OFS_CTRL, 32'h39);
    kick(250);
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[23:16], 8'h3, "start ignored");
    apb(1'b1, `FSL_OFS_CTRL, 32'h38);
    block_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(blocked, 1'b1, "block input");
    block_in <= 1'b0;
    repeat (10) @(posedge pclk);
    // store on-events only: the off-event must not appear
    n = ev_cnt;
    apb(1'b1, `FSL_OFS_CTRL, 32'h29);
    repeat (10) @(posedge pclk);
    chk(ev_cnt, n + 1, "on stored");
    // back to on: blocked-off is dropped, the spent starts raise inhibit-on again
    apb(1'b1, `FSL_OFS_CTRL, 32'h28);
    repeat (10) @(posedge pclk);
    chk(ev_cnt, n + 2, "off dropped");
    chk(last_code, FSL_EV_INH_ON, "on kept");
    // an unknown mode is refused while the store bits still land
    apb(1'b1, `FSL_OFS_CTRL, 32'h3f);
    apb(1'b0, `FSL_OFS_CTRL, 32'h0);
    chk(rd, 32'h38, "bad mode kept out");
    // hot only strictly above the limit
    heat_req <= lim + 10'h1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[3], 1'b1, "hot");
    heat_req <= lim;
    repeat (5) @(posedge pclk);
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[3], 1'b0, "at limit cold");
    // no cold stall given: the hot stall sizes each start, so four are counted
    apb(1'b1, `FSL_OFS_CTRL, 32'h18);
    repeat (120) @(posedge pclk);
    apb(1'b0, `FSL_OFS_STATUS, 32'h0);
    chk(rd[23:16], 8'h4, "cold stall falls back");
    tally_and_finish();
  end
endmodule
